/* hbp_host_port.sv */
// Host parallel bus port with interrupt pending, in-service and daisy chain.
// Assumes strobes from an asynchronous host; one core clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "hbp_cfg.svh"

module hbp_host_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Host bus pins
  input wire logic chipSelect_n,
  input wire logic channelSel,
  input wire logic ctrlDataSel,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic int_ack_n,
  input wire logic [`HBP_DATA_W-1:0] dataIn,
  output logic [`HBP_DATA_W-1:0] dataOut,
  output logic dataOe_n,
  // Interrupt pins
  output logic intReqOut,
  output logic intReqOe_n,
  input wire logic chain_enable_in,
  output logic chain_enable_out,
  // Serial core events and data
  input wire logic txEmptyEvt,
  input wire logic rxAvailEvt,
  input wire logic errorEvt,
  input wire logic statusEvt,
  input wire logic [`HBP_DATA_W-1:0] rxData,
  output logic [`HBP_DATA_W-1:0] txData,
  output logic txLoad,
  output logic rxTaken
);
  // Three-stage synchronisers, one vector per synchronised pin
  logic [2:0] rdSync_reg, wrSync_reg, ackSync_reg, ieiSync_reg;
  logic rdAct, wrAct, ackAct, ieiHigh;
  logic rdAct_reg, wrAct_reg;
  hbp_pkg::hbp_state_e state_reg;
  hbp_pkg::hbp_byte_t regs_reg [`HBP_NREG];
  logic [1:0] regIdx;
  logic [3:0] pending_flag;
  logic in_service_flag;
  logic lower_chain_disable;
  logic intEnable;
  logic [`HBP_DATA_W-1:0] vector_reg;
  logic selRead, selWrite, ackRead, ackCycle, anyPending;
  logic [3:0] evtVec;

  // Agreement of stages two and three counts as a change
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // Sample asynchronous pins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdSync_reg <= 3'h7;
      wrSync_reg <= 3'h7;
      ackSync_reg <= 3'h7;
      ieiSync_reg <= 3'h0;
    end else begin
      rdSync_reg <= {rdSync_reg[1:0], read_n};
      wrSync_reg <= {wrSync_reg[1:0], write_n};
      ackSync_reg <= {ackSync_reg[1:0], int_ack_n};
      ieiSync_reg <= {ieiSync_reg[1:0], chain_enable_in};
    end
  end

  // Filtered levels held between agreements
  logic rdLvl_reg, wrLvl_reg, ackLvl_reg, ieiLvl_reg;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdLvl_reg <= 1'b1;
      wrLvl_reg <= 1'b1;
      ackLvl_reg <= 1'b1;
      ieiLvl_reg <= 1'b0;
    end else begin
      rdLvl_reg <= agreed(rdSync_reg, rdLvl_reg);
      wrLvl_reg <= agreed(wrSync_reg, wrLvl_reg);
      ackLvl_reg <= agreed(ackSync_reg, ackLvl_reg);
      ieiLvl_reg <= agreed(ieiSync_reg, ieiLvl_reg);
    end
  end

  // Decoded controls; selects are stable while a strobe is active
  assign rdAct = !rdLvl_reg;
  assign wrAct = !wrLvl_reg;
  assign ackAct = !ackLvl_reg;
  assign ieiHigh = ieiLvl_reg;
  assign ackCycle = ackAct;
  assign regIdx = {channelSel, ctrlDataSel};
  assign selRead = rdAct && !wrAct && !ackAct && !chipSelect_n;
  assign selWrite = wrAct && !rdAct && !ackAct && !chipSelect_n;
  assign ackRead = ackAct && rdAct && !wrAct;
  assign evtVec = {statusEvt, errorEvt, rxAvailEvt, txEmptyEvt};
  assign anyPending = |pending_flag;

  // Access sequencer: one action per strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= hbp_pkg::HBP_IDLE;
      rdAct_reg <= 1'b0;
      wrAct_reg <= 1'b0;
    end else begin
      rdAct_reg <= rdAct;
      wrAct_reg <= wrAct;
      case (state_reg)
        hbp_pkg::HBP_IDLE: begin
          if (rdAct && wrAct) begin
            state_reg <= hbp_pkg::HBP_RESET;
          end else if (rdAct) begin
            state_reg <= hbp_pkg::HBP_READ;
          end else if (wrAct) begin
            state_reg <= hbp_pkg::HBP_WRITE;
          end
        end
        hbp_pkg::HBP_READ: begin
          if (rdAct && wrAct) begin
            state_reg <= hbp_pkg::HBP_RESET;
          end else if (!rdAct) begin
            state_reg <= hbp_pkg::HBP_IDLE;
          end
        end
        hbp_pkg::HBP_WRITE: begin
          if (rdAct && wrAct) begin
            state_reg <= hbp_pkg::HBP_RESET;
          end else if (!wrAct) begin
            state_reg <= hbp_pkg::HBP_IDLE;
          end
        end
        default: begin
          if (!rdAct && !wrAct) begin
            state_reg <= hbp_pkg::HBP_IDLE;
          end
        end
      endcase
    end
  end

  // Strobe-combination reset reaches every control register
  logic softReset;
  assign softReset = rdAct && wrAct;
  logic wrStart, rdStart;
  assign wrStart = selWrite && !wrAct_reg && state_reg == hbp_pkg::HBP_IDLE;
  assign rdStart = selRead && !rdAct_reg && state_reg == hbp_pkg::HBP_IDLE;
  logic cmdWrite;
  assign cmdWrite = wrStart && !ctrlDataSel;

  // Register file captures write data at strobe start
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      for (int i = 0; i < `HBP_NREG; i++) begin
        regs_reg[i] <= `HBP_REG_RESET;
      end
    end else if (wrStart) begin
      regs_reg[regIdx] <= dataIn;
    end
  end

  // Vector, chain disable and interrupt enable commands
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      lower_chain_disable <= 1'b0;
      intEnable <= 1'b0;
      vector_reg <= `HBP_VECTOR_RESET;
    end else if (cmdWrite) begin
      if (dataIn == `HBP_CMD_LOWER_CHAIN_DIS) begin
        lower_chain_disable <= 1'b1;
      end else if (dataIn == `HBP_CMD_LOWER_CHAIN_EN) begin
        lower_chain_disable <= 1'b0;
      end else if (dataIn == `HBP_CMD_ENABLE_INT) begin
        intEnable <= 1'b1;
      end else if (dataIn == `HBP_CMD_DISABLE_INT) begin
        intEnable <= 1'b0;
      end else if (channelSel) begin
        vector_reg <= dataIn;
      end
    end
  end

  // Pending flags: set wins over clear, acknowledge leaves them alone
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      pending_flag <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (evtVec[i]) begin
          pending_flag[i] <= 1'b1;
        end else if (i == 0 && ((wrStart && ctrlDataSel) || (cmdWrite && dataIn == `HBP_CMD_RESET_TX_PEND))) begin
          pending_flag[i] <= 1'b0;
        end else if (i == 1 && rdStart && ctrlDataSel) begin
          pending_flag[i] <= 1'b0;
        end else if (i > 1 && cmdWrite && dataIn == `HBP_CMD_RESET_TX_PEND) begin
          pending_flag[i] <= 1'b0;
        end
      end
    end
  end

  // Vector answer: held only through the acknowledge read that won it,
  // so a device already in service never answers a later acknowledge
  logic answerNow, vecAnswer_reg;
  assign answerNow = ackRead && anyPending && ieiHigh && !in_service_flag;
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      vecAnswer_reg <= 1'b0;
    end else begin
      vecAnswer_reg <= answerNow || (vecAnswer_reg && ackRead);
    end
  end

  // In-service flag: set by answered acknowledge, cleared by command only
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      in_service_flag <= 1'b0;
    end else if (ackRead && anyPending && ieiHigh && !in_service_flag) begin
      in_service_flag <= 1'b1;
    end else if (cmdWrite && dataIn == `HBP_CMD_RESET_IN_SERVICE) begin
      in_service_flag <= 1'b0;
    end
  end

  // Data bus drive: register read or acknowledge vector
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      dataOut <= `HBP_REG_RESET;
      dataOe_n <= 1'b1;
    end else if (ackRead && anyPending && ieiHigh && !in_service_flag) begin
      dataOut <= vector_reg;
      dataOe_n <= 1'b0;
    end else if (ackRead && vecAnswer_reg) begin
      dataOut <= vector_reg;
      dataOe_n <= 1'b0;
    end else if (selRead) begin
      dataOut <= (regIdx[0]) ? rxData : regs_reg[regIdx];
      dataOe_n <= 1'b0;
    end else begin
      dataOut <= `HBP_REG_RESET;
      dataOe_n <= 1'b1;
    end
  end

  // Chain enable out and open-drain request
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      chain_enable_out <= 1'b0;
      intReqOut <= 1'b0;
      intReqOe_n <= 1'b1;
    end else begin
      if (lower_chain_disable || !ieiHigh || in_service_flag) begin
        chain_enable_out <= 1'b0;
      end else if (ackCycle && anyPending) begin
        chain_enable_out <= 1'b0;
      end else begin
        chain_enable_out <= 1'b1;
      end
      intReqOut <= 1'b0;
      if (ackCycle) begin
        intReqOe_n <= intReqOe_n | !(intEnable && anyPending && ieiHigh && !in_service_flag);
      end else begin
        intReqOe_n <= !(intEnable && anyPending && ieiHigh && !in_service_flag);
      end
    end
  end

  // Strobes toward the serial core
  always_ff @(posedge core_clk) begin
    if (!reset_n || softReset) begin
      txData <= `HBP_REG_RESET;
      txLoad <= 1'b0;
      rxTaken <= 1'b0;
    end else begin
      txLoad <= wrStart && ctrlDataSel;
      rxTaken <= rdStart && ctrlDataSel;
      if (wrStart && ctrlDataSel) begin
        txData <= dataIn;
      end
    end
  end

  // Checks
  acknowledge_no_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ackCycle && !softReset && |pending_flag && !cmdWrite && !rdStart) |=> |pending_flag)
    else $error("pending cleared by acknowledge");
  in_service_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(in_service_flag) |-> $past(ackRead) && $past(ieiHigh) && $past(anyPending))
    else $error("in-service set without cause");
  in_service_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(in_service_flag) |-> $past(cmdWrite) || $past(softReset) || !$past(reset_n))
    else $error("in-service cleared without command");
  chain_disable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    lower_chain_disable |=> !chain_enable_out)
    else $error("chain out high while disabled");
  chain_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!ackCycle && !softReset && !lower_chain_disable && ieiHigh && !in_service_flag) |=> chain_enable_out)
    else $error("chain out low in idle");
  chain_ack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ackCycle && anyPending) |=> !chain_enable_out)
    else $error("chain out high with pending in acknowledge");
  no_new_request_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ackCycle && intReqOe_n && !softReset) |=> intReqOe_n)
    else $error("new request during acknowledge");
  read_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!selRead && !ackRead) |=> dataOe_n)
    else $error("bus driven without read");
  strobe_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    softReset |=> !in_service_flag && pending_flag == 4'h0)
    else $error("strobe reset ignored");
  vector_answer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ackAct && !dataOe_n) |-> $past(answerNow) || $past(vecAnswer_reg))
    else $error("vector driven without answer");
  rx_pending_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rdStart && ctrlDataSel && !rxAvailEvt) |=> !pending_flag[1])
    else $error("receive pending kept after data read");
  tx_pending_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wrStart && ctrlDataSel && !txEmptyEvt) |=> !pending_flag[0])
    else $error("transmit pending kept after data write");
endmodule // hbp_host_port
`default_nettype wire

/* hbp_cfg.svh */
// Constants for the host bus port with interrupt daisy chain.
// Assumes inclusion by hbp_pkg.sv and the port module.
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH
`define HBP_DATA_W 8
`define HBP_NREG 4
`define HBP_SYNC_STAGES 3
// Register index (channel, control/data)
`define HBP_REG_A_CTRL 2'h0
`define HBP_REG_A_DATA 2'h1
`define HBP_REG_B_CTRL 2'h2
`define HBP_REG_B_DATA 2'h3
// Commands written to a control register
`define HBP_CMD_RESET_TX_PEND 8'h28
`define HBP_CMD_RESET_IN_SERVICE 8'h38
`define HBP_CMD_LOWER_CHAIN_DIS 8'h04
`define HBP_CMD_LOWER_CHAIN_EN 8'h00
`define HBP_CMD_ENABLE_INT 8'h08
`define HBP_CMD_DISABLE_INT 8'h09
`define HBP_VECTOR_RESET 8'h00
`define HBP_REG_RESET 8'h00
`endif

/* hbp_pkg.sv */
// Types for the host bus port with interrupt daisy chain.
// Assumes hbp_cfg.svh is on the include path.
`include "hbp_cfg.svh"
package hbp_pkg;
  // Access sequencer states
  typedef enum logic [1:0] {
    HBP_IDLE = 2'b00,
    HBP_READ = 2'b01,
    HBP_WRITE = 2'b10,
    HBP_RESET = 2'b11
  } hbp_state_e;
  typedef logic [`HBP_DATA_W-1:0] hbp_byte_t;
endpackage

/* hbp_host_model.sv */
// Host processor model: drives select, strobe and acknowledge cycles.
// Assumes one core clock; all pins change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module hbp_host_model (
  // Clock
  input wire logic core_clk,
  // Device bus drive
  input wire logic [7:0] dataOut,
  input wire logic dataOe_n,
  // Host outputs
  output logic chipSelect_n,
  output logic channelSel,
  output logic ctrlDataSel,
  output logic read_n,
  output logic write_n,
  output logic int_ack_n,
  output logic [7:0] dataIn
);
  logic [7:0] hostData = 8'h00;
  logic hostOe = 1'b0;
  // Bus level: device, else host, else inverse of last host byte
  assign dataIn = !dataOe_n ? dataOut : (hostOe ? hostData : ~hostData);
  // Idle bus: chip select only asserted inside accesses
  initial begin
    chipSelect_n = 1'b1;
    {channelSel, ctrlDataSel} = 2'h0;
    {read_n, write_n, int_ack_n} = 3'h7;
  end
  // Board decoder: four registers at C0h..C3h of each page, images up to FFh
  function automatic logic decodeHit(input logic [7:0] ioAddr);
    decodeHit = (ioAddr[7:6] == 2'h3);
  endfunction
  // Write: data and selects before the strobe, held past it
  task automatic wr(input logic [7:0] ioAddr, input logic [7:0] d);
    @(posedge core_clk);
    chipSelect_n <= !decodeHit(ioAddr);
    {channelSel, ctrlDataSel} <= ioAddr[1:0];
    hostData <= d;
    hostOe <= 1'b1;
    @(posedge core_clk);
    write_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    write_n <= 1'b1;
    @(posedge core_clk);
    chipSelect_n <= 1'b1;
    hostOe <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // Read or acknowledge read; samples the bus while the strobe is low
  task automatic rd(input logic [7:0] ioAddr, input logic ack,
                    output logic [7:0] d, output logic oe);
    @(posedge core_clk);
    chipSelect_n <= ack || !decodeHit(ioAddr);
    {channelSel, ctrlDataSel} <= ioAddr[1:0];
    int_ack_n <= ~ack;
    repeat (4) @(posedge core_clk);
    read_n <= 1'b0;
    repeat (7) @(posedge core_clk);
    d = dataIn;
    oe = dataOe_n;
    read_n <= 1'b1;
    @(posedge core_clk);
    chipSelect_n <= 1'b1;
    int_ack_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // Both strobes low together to reset the device
  task automatic both();
    @(posedge core_clk);
    chipSelect_n <= 1'b0;
    {read_n, write_n} <= 2'h0;
    repeat (8) @(posedge core_clk);
    {read_n, write_n} <= 2'h3;
    @(posedge core_clk);
    chipSelect_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
endmodule // hbp_host_model
`default_nettype wire

/* test_host_bus_port_daisy_chain.sv */
// Self-checking bench for the host bus port and daisy chain.
// Assumes hbp_host_model drives the host pins; events come from here.
`timescale 1ns/1ns
`default_nettype none
module test_host_bus_port_daisy_chain;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chipSelect_n, channelSel, ctrlDataSel, read_n, write_n, int_ack_n;
  logic [7:0] dataIn, dataOut, txData, d;
  logic dataOe_n, intReqOut, intReqOe_n, chainOut, txLoad, rxTaken, oe;
  logic chainIn = 1'b1;
  logic [3:0] evt = 4'h0;
  int n_errors = 0;
  int samples_checked = 0;
  int loads = 0;
  int takes = 0;
  logic [7:0] lastTx = 8'h00;
  // Open-drain request line with pull-up
  wire intLine_n = intReqOe_n ? 1'b1 : intReqOut;
  // Clock
  always #5 core_clk = ~core_clk;
  hbp_host_port uut (.core_clk(core_clk), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
    .channelSel(channelSel), .ctrlDataSel(ctrlDataSel), .read_n(read_n), .write_n(write_n),
    .int_ack_n(int_ack_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .intReqOut(intReqOut), .intReqOe_n(intReqOe_n), .chain_enable_in(chainIn),
    .chain_enable_out(chainOut), .txEmptyEvt(evt[0]), .rxAvailEvt(evt[1]), .errorEvt(evt[2]),
    .statusEvt(evt[3]), .rxData(8'h5A), .txData(txData), .txLoad(txLoad), .rxTaken(rxTaken));
  hbp_host_model host (.core_clk(core_clk), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .chipSelect_n(chipSelect_n), .channelSel(channelSel), .ctrlDataSel(ctrlDataSel),
    .read_n(read_n), .write_n(write_n), .int_ack_n(int_ack_n), .dataIn(dataIn));
  // Counts transmit loads and receive takes
  always @(posedge core_clk) begin
    if (txLoad === 1'b1) begin
      loads++;
      lastTx <= txData;
    end
    if (rxTaken === 1'b1) takes++;
  end
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt[i] <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_rw();
    int l0;
    l0 = loads;
    host.wr(8'hE1, 8'hC3);
    check(loads == l0 + 1 && lastTx === 8'hC3, "data write not loaded");
    host.wr(8'hC0, 8'h00);
    check(loads == l0 + 1, "control write loaded data");
    l0 = takes;
    host.rd(8'hC3, 1'b0, d, oe);
    check(d === 8'h5A && oe === 1'b0, "data read wrong");
    check(dataOe_n === 1'b1 && takes == l0 + 1, "bus kept or no take");
    host.rd(8'h41, 1'b0, d, oe);
    check(oe === 1'b1, "drove bus unselected");
  endtask
  task automatic t_chain();
    chainIn <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(chainOut === 1'b0, "chain out high, in low");
    chainIn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(chainOut === 1'b1, "chain out low, idle");
    host.wr(8'hC0, 8'h04);
    check(chainOut === 1'b0, "lower chain not disabled");
    host.wr(8'hC0, 8'h00);
    check(chainOut === 1'b1, "lower chain not restored");
  endtask
  task automatic t_events();
    host.wr(8'hC2, 8'hA5);
    host.rd(8'hC2, 1'b0, d, oe);
    check(d === 8'hA5 && oe === 1'b0, "control register not kept");
    host.wr(8'hC0, 8'h08);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      check(intLine_n === 1'b0, "no request for event");
      if (i == 1) host.rd(8'hC1, 1'b0, d, oe);
      else host.wr(8'hC0, 8'h28);
      check(intLine_n === 1'b1, "pending not cleared");
    end
    pulse(0);
    host.wr(8'hC1, 8'h11);
    check(intLine_n === 1'b1, "data write kept tx pending");
    host.wr(8'hC0, 8'h09);
    pulse(2);
    check(intLine_n === 1'b1, "request while disabled");
    host.wr(8'hC0, 8'h28);
    host.wr(8'hC0, 8'h08);
  endtask
  task automatic t_ack();
    pulse(0);
    chainIn <= 1'b0;
    host.rd(8'h00, 1'b1, d, oe);
    check(oe === 1'b1 && chainOut === 1'b0, "answered with chain in low");
    chainIn <= 1'b1;
    repeat (8) @(posedge core_clk);
    host.rd(8'h00, 1'b1, d, oe);
    check(d === 8'hA5 && oe === 1'b0, "vector not driven");
    check(chainOut === 1'b0 && intLine_n === 1'b1, "in service not set");
    host.rd(8'h00, 1'b1, d, oe);
    check(oe === 1'b1, "in-service device answered again");
    host.wr(8'hC0, 8'h38);
    check(chainOut === 1'b1, "in service not cleared");
    check(intLine_n === 1'b0, "ack cleared pending");
  endtask
  task automatic t_hwreset();
    host.both();
    check(intLine_n === 1'b1 && dataOe_n === 1'b1, "strobe reset missed");
    pulse(0);
    check(intLine_n === 1'b1, "enable survived reset");
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] %0t timeout", $time);
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    check(dataOe_n === 1'b1 && intReqOe_n === 1'b1 && chainOut === 1'b0, "reset values");
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_rw();
    t_chain();
    t_events();
    t_ack();
    t_hwreset();
    stop_test();
  end
endmodule // test_host_bus_port_daisy_chain
`default_nettype wire
